// ===== ebah_arbiter_port.sv
// Bus-mastership handshake of the external memory port, device side.
// Assumes a central arbiter drives bus_grant_n asynchronously, an external
// pull-up on the shared busy line, and a memory sequencer on sys_clk that
// answers each accStart with one accDone pulse at least one cycle later.
//
// Functional notes
// - Hold request whenever the bus is needed
// - Grant counts only while busy is free
// - Drive busy high, then tri-state it
// - Take busy only when granted and free
// - Finish current access before releasing bus
// - Lock held through whole read-modify-write
// - Never release inside an atomic group
// - Request-hold bit keeps request asserted
// - Lock-hold bit keeps lock asserted unless port disabled
// - Status flag shows current mastership
// - Fast release together, slow releases busy last
// - Wait/stop releases bus, ignores grant
// - Parked master may keep busy asserted
// - Default master may take bus unrequested (this port always raises request first, even when already granted)
// - Keep busy through read-modify-write despite grant loss
// - Wait for busy high before taking it
// - Port disable releases request, lock, busy
//
// The register offsets and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ns
module ebah_arbiter_port
  import ebah_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // Avalon-MM register slave
  input  wire logic [3:0]  avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [31:0] avsWritedata,
  input  wire logic [3:0]  avsByteenable,
  output logic      [31:0] avsReaddata,
  output logic             avsWaitrequest,
  // Core side
  input  wire logic        accReq,
  input  wire logic [1:0]  accLen,
  input  wire logic        accRmw,
  input  wire logic        accDone,
  input  wire logic        waitStop,
  output logic             accStart,
  output logic             accGroupDone,
  output logic             masterFlag,
  // Arbitration pins
  output logic             bus_request_n,
  input  wire logic        bus_grant_n,
  input  wire logic        bus_busy_n_in,
  output logic             bus_busy_n_out,
  output logic             bus_busy_n_oe,
  output logic             bus_lock_n,
  output logic             portPinsOe
);

  ebah_state_t state;        // Handshake state
  ebah_state_t next_state;   // Next handshake state
  logic [3:0]  ctrl;         // Control register
  logic [1:0]  pinSync;      // {busy_n, grant_n} after synchroniser
  logic        grantSync;    // Grant active, synchronised
  logic        busySync;     // Busy active, synchronised
  logic        enabled;      // Port usable: not disabled, not in wait/stop
  logic        wantBus;      // Some reason to hold the bus
  logic [1:0]  grpLen;       // Accesses in group minus one
  logic [1:0]  accIdx;       // Index of running access
  logic        grpRmw;       // Group is a read-modify-write
  logic        lastDone;     // Final access of group finishes now
  logic        rmwNow;       // Group about to run or running is RMW
  logic        relSlowLat;   // Release mode caught at release start

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; idle level of both lines is high
  ebah_sync3 #(
    .WIDTH     (2),
    .RESET_VAL (2'h3)
  ) u_pinSync (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .pinIn   ({bus_busy_n_in, bus_grant_n}),
    .syncOut (pinSync)
  );

  // Decisions see only filtered samples, never the raw pins
  assign grantSync = !pinSync[0];
  assign busySync  = !pinSync[1];

  // Wait/stop and port disable both make the grant irrelevant
  assign enabled = !ctrl[EBAH_CTRL_DISABLE] && !waitStop;
  assign wantBus = enabled && (accReq || ctrl[EBAH_CTRL_REQ_HOLD]);
  assign lastDone = (state == EBAH_XFER) && accDone && (accIdx == grpLen);
  assign rmwNow = (state == EBAH_OWN) ? accRmw : grpRmw;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state decision
  always_comb begin
    next_state = state;
    unique case (state)
      EBAH_IDLE: begin
        // Default master path: grant alone plus accReq also lands here
        if (wantBus) begin
          next_state = EBAH_WAITBUS;
        end
      end
      EBAH_WAITBUS: begin
        if (!wantBus) begin
          next_state = EBAH_IDLE;
        end else if (grantSync && !busySync) begin
          next_state = EBAH_OWN;
        end
      end
      EBAH_OWN: begin
        // Grant lost, disabled or waiting: let go of the bus
        if (!enabled || !grantSync) begin
          next_state = EBAH_RELHIGH;
        end else if (accReq) begin
          next_state = EBAH_XFER;
        end
        // Otherwise stay parked with busy asserted
      end
      EBAH_XFER: begin
        // Grant loss is ignored until the whole group is through
        if (lastDone) begin
          if (!enabled || !grantSync) begin
            next_state = EBAH_RELHIGH;
          end else begin
            next_state = EBAH_OWN;
          end
        end
      end
      EBAH_RELHIGH: begin
        if (relSlowLat) begin
          next_state = EBAH_RELSLOW;
        end else begin
          next_state = EBAH_IDLE;
        end
      end
      EBAH_RELSLOW: begin
        next_state = EBAH_IDLE;
      end
      default: begin
        next_state = EBAH_IDLE;  // Illegal code recovers to idle
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state <= EBAH_IDLE;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Release mode is frozen when release starts, so a late write cannot
  // cut the slow sequence short
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      relSlowLat <= 1'b0;
    end else if (next_state == EBAH_RELHIGH && state != EBAH_RELHIGH) begin
      relSlowLat <= ctrl[EBAH_CTRL_REL_SLOW];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Busy line and port pins, decoded from the next state
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      bus_busy_n_out <= 1'b1;
      bus_busy_n_oe  <= 1'b0;
      portPinsOe     <= 1'b0;
      masterFlag     <= 1'b0;
    end else begin
      unique case (next_state)
        EBAH_OWN, EBAH_XFER: begin
          bus_busy_n_out <= 1'b0;
          bus_busy_n_oe  <= 1'b1;
          portPinsOe     <= 1'b1;
          masterFlag     <= 1'b1;
        end
        EBAH_RELHIGH: begin
          bus_busy_n_out <= 1'b1;
          bus_busy_n_oe  <= 1'b1;
          portPinsOe     <= 1'b1;
          masterFlag     <= 1'b0;
        end
        EBAH_RELSLOW: begin
          bus_busy_n_out <= 1'b1;
          bus_busy_n_oe  <= 1'b1;
          portPinsOe     <= 1'b0;
          masterFlag     <= 1'b0;
        end
        default: begin
          bus_busy_n_out <= 1'b1;  // Released; pull-up holds the line
          bus_busy_n_oe  <= 1'b0;
          portPinsOe     <= 1'b0;
          masterFlag     <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request and lock lines
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      bus_request_n <= 1'b1;
      bus_lock_n    <= 1'b1;
    end else begin
      // Request follows demand, the hold bit, or a running group
      bus_request_n <= !(wantBus || (enabled && next_state == EBAH_XFER));
      // Lock through an RMW group, or under the hold bit unless the port is disabled
      bus_lock_n <= ctrl[EBAH_CTRL_DISABLE] ||
                    !(ctrl[EBAH_CTRL_LOCK_HOLD] ||
                      (next_state == EBAH_XFER && rmwNow));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Atomic group sequencing: one accStart per access, counted to grpLen
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      grpLen       <= 2'h0;
      grpRmw       <= 1'b0;
      accIdx       <= 2'h0;
      accStart     <= 1'b0;
      accGroupDone <= 1'b0;
    end else begin
      accStart     <= 1'b0;
      accGroupDone <= lastDone;
      if (state == EBAH_OWN && next_state == EBAH_XFER) begin
        grpLen   <= accLen;
        grpRmw   <= accRmw;
        accIdx   <= 2'h0;
        accStart <= 1'b1;
      end else if (state == EBAH_XFER && accDone && !lastDone) begin
        accIdx   <= accIdx + 2'h1;
        accStart <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, then the answer
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      avsWaitrequest <= 1'b1;
    end else begin
      avsWaitrequest <= !((avsRead || avsWrite) && avsWaitrequest);
    end
  end

  // Control writes land on the edge where waitrequest is low
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ctrl <= EBAH_CTRL_RESET;
    end else if (avsWrite && !avsWaitrequest && avsByteenable[0] &&
                 avsAddress == EBAH_OFF_CTRL) begin
      ctrl <= avsWritedata[3:0];
    end
  end

  // Read data prepared one cycle ahead; unmapped offsets read zero
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      avsReaddata <= 32'h0;
    end else if (avsRead && avsWaitrequest) begin
      avsReaddata <= 32'h0;
      if (avsAddress == EBAH_OFF_CTRL) begin
        avsReaddata[3:0] <= ctrl;
      end else if (avsAddress == EBAH_OFF_STATUS) begin
        avsReaddata[EBAH_STAT_MASTER] <= masterFlag;
        avsReaddata[EBAH_STAT_GRANT]  <= grantSync;
        avsReaddata[EBAH_STAT_BUSY]   <= busySync;
        avsReaddata[EBAH_STAT_STATE +: 3] <= state;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_take_free_bus: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    $rose(masterFlag) && $past(state) == EBAH_WAITBUS |->
      $past(grantSync) && !$past(busySync))
    else $error("Busy taken without grant or while bus busy");

  chk_release_high: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    $fell(bus_busy_n_oe) |-> $past(bus_busy_n_out) && bus_busy_n_out)
    else $error("Busy released without driving high first");

  chk_slow_order: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    $fell(portPinsOe) && relSlowLat |-> bus_busy_n_oe ##1 !bus_busy_n_oe)
    else $error("Slow release did not leave busy one cycle last");

  chk_fast_order: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    $fell(portPinsOe) && !relSlowLat |-> !bus_busy_n_oe)
    else $error("Fast release did not free all pins together");

  chk_group_hold: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    state == EBAH_XFER |-> bus_busy_n_oe && !bus_busy_n_out && masterFlag)
    else $error("Mastership dropped inside an access group");

  chk_lock_rmw: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    state == EBAH_XFER && grpRmw && !$past(ctrl[EBAH_CTRL_DISABLE]) |-> !bus_lock_n)
    else $error("Lock not held during read-modify-write");

  chk_lock_hold: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    $past(ctrl[EBAH_CTRL_LOCK_HOLD]) && !$past(ctrl[EBAH_CTRL_DISABLE]) |-> !bus_lock_n)
    else $error("Lock-hold bit set but lock not asserted");

  chk_disable_free: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    $past(ctrl[EBAH_CTRL_DISABLE]) |-> bus_request_n && bus_lock_n)
    else $error("Disabled port still requests or locks");

  chk_wait_release: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    $past(waitStop) |-> bus_request_n)
    else $error("Request asserted during wait or stop");

  chk_req_cause: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    !bus_request_n |->
      $past(ctrl[EBAH_CTRL_REQ_HOLD]) || $past(accReq) || state == EBAH_XFER)
    else $error("Request asserted with no demand and hold clear");

endmodule // ebah_arbiter_port

// ===== ebah_pkg.sv
// Shared constants for the external bus arbitration handshake block.
// Assumes a 32-bit Avalon-MM register bus and a single core clock.
package ebah_pkg;

  // Register byte offsets
  localparam logic [3:0] EBAH_OFF_CTRL   = 4'h0;  // Control bits, read/write
  localparam logic [3:0] EBAH_OFF_STATUS = 4'h4;  // Status bits, read only

  // Control register field positions
  localparam int EBAH_CTRL_REQ_HOLD  = 0;  // request_hold_bit
  localparam int EBAH_CTRL_LOCK_HOLD = 1;  // lock_hold_bit
  localparam int EBAH_CTRL_REL_SLOW  = 2;  // release_timing_select, 1 = slow
  localparam int EBAH_CTRL_DISABLE   = 3;  // external_port_disable

  // Control register reset value: everything cleared
  localparam logic [3:0] EBAH_CTRL_RESET = 4'h0;

  // Status register field positions
  localparam int EBAH_STAT_MASTER = 0;  // master_state_flag
  localparam int EBAH_STAT_GRANT  = 1;  // Synchronised grant seen active
  localparam int EBAH_STAT_BUSY   = 2;  // Synchronised busy seen active
  localparam int EBAH_STAT_STATE  = 4;  // Handshake state, three bits

  // Synchroniser depth for pin inputs
  localparam int EBAH_SYNC_STAGES = 3;

  // Handshake states
  typedef enum logic [2:0] {
    EBAH_IDLE    = 3'b000,  // Not master, pins released
    EBAH_WAITBUS = 3'b001,  // Requesting, waiting for grant and free bus
    EBAH_OWN     = 3'b010,  // Master, no access running (may be parked)
    EBAH_XFER    = 3'b011,  // Master, atomic access group running
    EBAH_RELHIGH = 3'b100,  // Busy driven high before release
    EBAH_RELSLOW = 3'b101   // Other pins off, busy still driven high
  } ebah_state_t;

endpackage : ebah_pkg

// ===== ebah_sync3.sv
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes the inputs come from outside the sys_clk domain.
`timescale 1ns/1ns
module ebah_sync3 #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1;  // Metastability catcher, read by stage2 only
  logic [WIDTH-1:0] stage2;  // Second stage
  logic [WIDTH-1:0] stage3;  // Third stage

  ////////////////////////////////////////////////////////////////////////////
  // Shift chain
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      stage1 <= RESET_VAL;
      stage2 <= RESET_VAL;
      stage3 <= RESET_VAL;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output changes only once stage2 and stage3 agree, per bit
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      syncOut <= RESET_VAL;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          syncOut[i] <= stage3[i];
        end
      end
    end
  end

endmodule // ebah_sync3

// ===== ebah_far_arb.sv
// Far-side model: central arbiter, one rival master and the busy pull-up.
// Assumes the bench steers rival requests and arbiter policy by its inputs.
`timescale 1ns/1ns
module ebah_far_arb (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic bus_request_n,
  input  wire logic busyOut,    // Device busy drive value
  input  wire logic busyOe,     // Device busy enable
  input  wire logic withhold,   // A higher-priority rival wins
  input  wire logic otherHold,  // Rival master pulls busy low
  input  wire logic defMaster,  // Device is the default master
  input  wire logic slowArb,    // Answer three cycles late
  output logic      bus_grant_n,
  output logic      busyLine
);
  logic [3:0] grantPipe;  // Grant decisions, newest in bit 0
  logic       grantNow;   // Decision for this cycle

  ////////////////////////////////////////////////////////////
  // Wired busy line: pull-up unless a party pulls it low
  assign busyLine = (busyOe ? busyOut : 1'b1) & ~otherHold;
  // Park on the owner; a rival win drops our grant, one grant only
  assign grantNow = ~withhold & (grantPipe[0] | ~bus_request_n | defMaster);

  // Decision history, so a slow arbiter can answer late
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      grantPipe <= 4'h0;
    end else begin
      grantPipe <= {grantPipe[2:0], grantNow};
    end
  end
  assign bus_grant_n = ~(slowArb ? grantPipe[3] : grantPipe[0]);
endmodule // ebah_far_arb

// ===== tb_top.sv
// Self-checking bench for the arbitration handshake port.
// Assumes the package, design and far-side model are compiled first.
`timescale 1ns/1ns
module tb_top
  import ebah_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [3:0]  avsAddress = 4'h0;
  logic        avsRead = 1'b0;
  logic        avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h0;
  logic [3:0]  avsByteenable = 4'hf;
  logic [31:0] avsReaddata;
  logic        avsWaitrequest;
  logic [1:0]  accLen = 2'h0;
  logic        accReq = 1'b0, accRmw = 1'b0, accDone = 1'b0, waitStop = 1'b0;
  logic        accStart, accGroupDone, masterFlag, bus_request_n, bus_grant_n;
  logic        busyLine, bus_busy_n_out, bus_busy_n_oe, bus_lock_n, portPinsOe;
  logic        withhold = 1'b1, otherHold = 1'b0, defMaster = 1'b0, slowArb = 1'b0;
  logic [3:0]  ctrlShadow = 4'h0;  // Model of the control bits
  logic [31:0] v, v2;               // Scratch words
  integer      seed = 32'h066e9cf6;
  int          bad_count = 0, compares = 0, cycles = 0, starts = 0, dly = 0, i;
  int          expAcc[$];           // Model: accesses owed by each group

  ebah_arbiter_port i_dut (.sys_clk(sys_clk), .rstn(rstn), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
    .avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .accReq(accReq), .accLen(accLen), .accRmw(accRmw),
    .accDone(accDone), .waitStop(waitStop), .accStart(accStart),
    .accGroupDone(accGroupDone), .masterFlag(masterFlag), .bus_request_n(bus_request_n),
    .bus_grant_n(bus_grant_n), .bus_busy_n_in(busyLine), .bus_busy_n_out(bus_busy_n_out),
    .bus_busy_n_oe(bus_busy_n_oe), .bus_lock_n(bus_lock_n), .portPinsOe(portPinsOe));
  ebah_far_arb i_far (.sys_clk(sys_clk), .rstn(rstn), .bus_request_n(bus_request_n),
    .busyOut(bus_busy_n_out), .busyOe(bus_busy_n_oe), .withhold(withhold),
    .otherHold(otherHold), .defMaster(defMaster), .slowArb(slowArb),
    .bus_grant_n(bus_grant_n), .busyLine(busyLine));

  ////////////////////////////////////////////////////////////
  always #5 sys_clk = ~sys_clk;

  // Verdict and end of run
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Hang guard, well above the run's length
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count = bad_count + 1;
      report_and_stop();
    end
  end

  // Single comparison point
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  ////////////////////////////////////////////////////////////
  // Avalon cycle; entered just after an edge, leaves one idle cycle
  task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] rd);
    avsAddress <= a;
    avsWritedata <= d;
    avsByteenable <= be;
    avsWrite <= wr;
    avsRead <= ~wr;
    @(posedge sys_clk);
    while (avsWaitrequest !== 1'b0) @(posedge sys_clk);
    rd = avsReaddata;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] rd;
    avs(1'b1, a, d, be, rd);
    if (a == EBAH_OFF_CTRL && be[0]) ctrlShadow = d[3:0];
  endtask

  ////////////////////////////////////////////////////////////
  // Memory sequencer: ends each access two to four cycles after its accStart
  always @(posedge sys_clk) begin
    accDone <= (accStart !== 1'b1) && (dly == 1);
    if (accStart === 1'b1) begin
      dly <= 1 + {$random(seed)} % 3;
    end else if (dly > 0) begin
      dly <= dly - 1;
    end
  end

  // Pin monitor on every edge
  always @(posedge sys_clk) begin
    if (rstn === 1'b1 && masterFlag === 1'b1) begin
      chk("busy drive", {bus_busy_n_oe, bus_busy_n_out}, 2'b10);
    end
    if (otherHold === 1'b1) begin
      chk("taken early", bus_busy_n_oe & ~bus_busy_n_out, 1'b0);
    end
    if (accStart === 1'b1) begin
      starts <= starts + 1;
      chk("xfer busy", {bus_busy_n_oe, bus_busy_n_out}, 2'b10);
      chk("lock", bus_lock_n, !(accRmw || ctrlShadow[1]));
    end
  end

  // One access group; cut withdraws the grant right after it starts
  task automatic runGroup(input int len, input logic rmw, input logic cut);
    int s0;
    expAcc.push_back(len + 1);
    accLen <= len[1:0];
    accRmw <= rmw;
    accReq <= 1'b1;
    @(posedge sys_clk);
    while (accStart !== 1'b1) @(posedge sys_clk);
    s0 = starts;
    chk("request", bus_request_n, 1'b0);
    accReq <= 1'b0;
    if (cut) withhold <= 1'b1;
    @(posedge sys_clk);
    while (accGroupDone !== 1'b1) begin
      chk("mastership", masterFlag, 1'b1);
      @(posedge sys_clk);
    end
    chk("accesses", starts - s0, expAcc.pop_front());
  endtask

  // Release order from the first cycle without mastership
  task automatic chkRelease(input logic slow);
    while (masterFlag !== 1'b0) @(posedge sys_clk);
    chk("drive high", {bus_busy_n_oe, bus_busy_n_out, portPinsOe}, 3'b111);
    @(posedge sys_clk);
    chk("first off", {bus_busy_n_oe, portPinsOe}, {slow, 1'b0});
    if (slow) begin
      chk("busy last", bus_busy_n_out, 1'b1);
      @(posedge sys_clk);
      chk("busy off", bus_busy_n_oe, 1'b0);
    end
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    chk("reset pins", {bus_request_n, bus_lock_n, bus_busy_n_oe, masterFlag,
      portPinsOe, avsWaitrequest, accStart, accGroupDone}, 8'hc4);
    @(posedge sys_clk);
    // Control bits: random values, masked lane, unmapped place
    avs(1'b0, EBAH_OFF_CTRL, 32'h0, 4'hf, v2);
    chk("ctrl reset", v2, {28'h0, EBAH_CTRL_RESET});
    for (i = 0; i < 4; i++) begin
      v = $random(seed);
      wr(EBAH_OFF_CTRL, v, 4'h1);
      avs(1'b0, EBAH_OFF_CTRL, 32'h0, 4'hf, v2);
      chk("ctrl", v2, {28'h0, v[3:0]});
    end
    wr(EBAH_OFF_CTRL, ~v, 4'h0);
    avs(1'b0, EBAH_OFF_CTRL, 32'h0, 4'hf, v2);
    chk("ctrl lane", v2, {28'h0, ctrlShadow});
    avs(1'b0, 4'h8, 32'h0, 4'hf, v2);
    chk("unmapped", v2, 32'h0);
    wr(EBAH_OFF_CTRL, 32'h0, 4'h1);
    // Every group length, then parking
    withhold <= 1'b0;
    for (i = 0; i < 4; i++) begin
      runGroup(i, i == 1 || v[i], 1'b0);
      avs(1'b0, EBAH_OFF_STATUS, 32'h0, 4'hf, v2);
      chk("status master", v2, {25'h0, EBAH_OWN, 4'h7});
      repeat (8) begin
        @(posedge sys_clk);
        chk("parked", {masterFlag, bus_request_n}, 2'b11);
      end
    end
    // Grant lost mid read-modify-write, fast then slow release
    for (i = 0; i < 2; i++) begin
      wr(EBAH_OFF_CTRL, i << EBAH_CTRL_REL_SLOW, 4'h1);
      withhold <= 1'b0;
      runGroup(1, 1'b1, 1'b1);
      chkRelease(i[0]);
      avs(1'b0, EBAH_OFF_STATUS, 32'h0, 4'hf, v2);
      chk("status idle", {v2[6:4], v2[1:0]}, {EBAH_IDLE, 2'b00});
    end
    // Granted while a rival holds busy; arbiter re-picks meanwhile
    otherHold <= 1'b1;
    withhold <= 1'b0;
    accReq <= 1'b1;
    repeat (20) @(posedge sys_clk);
    withhold <= 1'b1;
    repeat (10) @(posedge sys_clk);
    withhold <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chk("no take", masterFlag, 1'b0);
    otherHold <= 1'b0;
    runGroup(0, 1'b0, 1'b0);
    // Hold bits while not master, then port disable ignoring grant
    withhold <= 1'b1;
    chkRelease(1'b1);
    wr(EBAH_OFF_CTRL, 32'h3, 4'h1);
    repeat (4) @(posedge sys_clk);
    chk("holds", {bus_request_n, bus_lock_n, masterFlag}, 3'b000);
    wr(EBAH_OFF_CTRL, 32'hb, 4'h1);
    defMaster <= 1'b1;
    withhold <= 1'b0;
    repeat (20) @(posedge sys_clk);
    chk("disabled", {bus_request_n, bus_lock_n, bus_busy_n_oe, masterFlag}, 4'hc);
    // Default master, slow arbiter, then wait/stop
    wr(EBAH_OFF_CTRL, 32'h0, 4'h1);
    slowArb <= 1'b1;
    runGroup(3, 1'b0, 1'b0);
    waitStop <= 1'b1;
    chkRelease(1'b0);
    accReq <= 1'b1;
    repeat (20) @(posedge sys_clk);
    chk("stopped", {bus_request_n, bus_busy_n_oe, masterFlag}, 3'b100);
    waitStop <= 1'b0;
    runGroup(0, 1'b0, 1'b0);
    report_and_stop();
  end
endmodule // tb_top
